// [verilog/seer_map.svh]
// Purpose: Constants for the serial EEPROM read-side target.
// Assumes: Included by bare name. Byte offsets on APB are multiples of four.
// Notes: The package seer_pkg holds the types.
//
// Contract
// - A read opens with start, 4-bit type, 3 select bits, read direction, then ACK.
// - Type 1010 reaches the main array; 1011 reaches ident, protect and serial areas.
// - Reads are served whatever the write-protect pin or soft protect bit say.
// - Current-address read sends the byte at the counter, then increments it.
// - The address counter keeps its value between bus operations while powered.
// - Main-array increments past the last byte wrap to byte zero.
// - One counter is shared by main array, ident page and serial number.
// - After the read select ACK, bytes keep flowing while each one is ACKed.
// - Ident read uses 1011, address bits 7:6 equal 00, bits 3:0 pick the byte.
// - Ident page reads wrap from its last byte to its first.
// - Ident write data byte is ACKed when unlocked and NACKed when locked.
// - A start after the lock probe discards the truncated write; stop gives standby.
// - Protect read, bits 7:6 equal 11, returns seven zeros and the protect bit.
// - Further bytes of a protect read repeat the same protect byte.
// - Serial read, bits 7:6 equal 01, bits 3:0 pick one of sixteen bytes.
// - Serial reads wrap from byte fifteen to byte zero.
// - The factory serial number can never be written.
// - During an internal write cycle the device NACKs every select byte.
// - The ident page is a separate 16-byte store that can be locked.
`ifndef SEER_MAP_SVH
`define SEER_MAP_SVH
`define SEER_TYPE_MAIN 4'ha
`define SEER_TYPE_AUX 4'hb
`define SEER_AREA_IDENT 2'h0
`define SEER_AREA_SERIAL 2'h1
`define SEER_AREA_LOCK 2'h2
`define SEER_AREA_PROT 2'h3
`define SEER_OFF_CTRL 12'h000
`define SEER_OFF_STAT 12'h004
`define SEER_OFF_ADDR 12'h008
`define SEER_CTRL_BUSY 0
`define SEER_CTRL_PROT 1
`define SEER_CTRL_LOCK 2
`define SEER_CTRL_SEL_LSB 4
`define SEER_CTRL_RESET 32'h0000_0000
`define SEER_SERIAL_BYTES 16
`endif

// [verilog/seer_pkg.sv]
// Purpose: Types for the serial EEPROM read-side target.
// Assumes: Nothing beyond the map header.
// Notes: States are numbered in declaration order; STAT reads them back.
package seer_pkg;
  typedef enum logic [3:0] {
    SEER_IDLE, SEER_DEVSEL, SEER_DS_ACK, SEER_WADDR, SEER_WA_ACK,
    SEER_WDATA, SEER_WD_ACK, SEER_RDATA, SEER_RD_ACK, SEER_IGNORE
  } seer_state_e;
  typedef logic [8:0] seer_addr_t;
endpackage

// [verilog/seer_sync.sv]
// Purpose: Two-flop synchroniser for the link pins.
// Assumes: pclk domain, asynchronous active-low reset.
// Notes: First stage is read only by the second.
module seer_sync #(
  parameter int W = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  // Pins idle high on an open-drain bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '1;
      q_reg <= '1;
    end else if (clk_en) begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
  assign q = q_reg;
endmodule

// [verilog/seer_top.sv]
// Purpose: Read-side I2C target of a 4-Kbit EEPROM with APB side registers.
// Assumes: scl and sda sampled by pclk; scl far slower than pclk.
// Notes: Ident page lives in flip-flops, serial number is constant wiring; writes to the main array are other logic's job.
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`include "seer_map.svh"
module seer_top
  import seer_pkg::*;
#(
  parameter logic [127:0] SERIAL_VALUE = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wp_pin
);
  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  logic [1:0] pin_s;
  logic scl_d_reg, sda_d_reg;
  logic scl_s, sda_s;
  seer_sync #(.W(2)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .d({scl_in, sda_in}),
    .q(pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];
  // Delayed copies for edge and condition detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (clk_en) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Main array stays zero here; programming belongs to the write path
  logic [7:0] ident_mem [16];
  logic [7:0] serial_byte [16];
  genvar gi;
  generate
    for (gi = 0; gi < `SEER_SERIAL_BYTES; gi++) begin : g_ser
      // Constant wiring, no write path exists
      assign serial_byte[gi] = SERIAL_VALUE[127-8*gi -: 8];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control registers over APB
  // ----------------------------------------------------------------
  logic busy_reg, busy_next;
  logic prot_reg, prot_next;
  logic lock_reg, lock_next;
  logic [2:0] sel_reg, sel_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic pready_reg, pready_next;
  logic acc;
  seer_addr_t cnt_reg, cnt_next;
  seer_state_e st_reg, st_next;
  assign acc = psel && penable && pready_reg;
  // One wait state: setup, access with pready low, access with pready high
  always_comb begin
    busy_next = busy_reg;
    prot_next = prot_reg;
    lock_next = lock_reg;
    sel_next = sel_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = psel && penable && !pready_reg;
    if (psel && penable && !pready_reg) begin
      pslverr_next = !(paddr == `SEER_OFF_CTRL || paddr == `SEER_OFF_STAT ||
                       paddr == `SEER_OFF_ADDR);
      case (paddr)
        `SEER_OFF_CTRL: prdata_next = {25'h0, sel_reg, 1'b0, lock_reg, prot_reg, busy_reg};
        `SEER_OFF_STAT: prdata_next = {28'h0, st_reg};
        `SEER_OFF_ADDR: prdata_next = {23'h0, cnt_reg};
        default: prdata_next = 32'h0;
      endcase
    end
    if (acc && pwrite && paddr == `SEER_OFF_CTRL) begin
      busy_next = pwdata[`SEER_CTRL_BUSY];
      prot_next = pwdata[`SEER_CTRL_PROT];
      // Lock is one way, as the page lock is permanent
      lock_next = lock_reg | pwdata[`SEER_CTRL_LOCK];
      sel_next = pwdata[`SEER_CTRL_SEL_LSB +: 3];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      prot_reg <= 1'b0;
      lock_reg <= 1'b0;
      sel_reg <= 3'h0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
    end else if (clk_en) begin
      busy_reg <= busy_next;
      prot_reg <= prot_next;
      lock_reg <= lock_next;
      sel_reg <= sel_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      pready_reg <= pready_next;
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------------------------------
  // Link engine
  // ----------------------------------------------------------------
  logic [7:0] sh_reg, sh_next;
  logic [3:0] bit_reg, bit_next;
  logic aux_reg, aux_next;
  logic [1:0] area_reg, area_next;
  logic sda_out_reg, sda_out_next;
  logic sda_oe_reg, sda_oe_next;
  logic [7:0] rd_byte;
  logic sel_ok;
  // Byte for the current source; wp_pin and prot never gate reads
  always_comb begin
    rd_byte = 8'h00;
    if (aux_reg) begin
      case (area_reg)
        `SEER_AREA_IDENT: rd_byte = ident_mem[cnt_reg[3:0]];
        `SEER_AREA_SERIAL: rd_byte = serial_byte[cnt_reg[3:0]];
        `SEER_AREA_PROT: rd_byte = {7'h00, prot_reg};
        default: rd_byte = 8'h00;
      endcase
    end
  end
  // Select bits 3:2 must match; bit 1 is the array's top address bit
  assign sel_ok = (sh_reg[7:4] == `SEER_TYPE_MAIN || sh_reg[7:4] == `SEER_TYPE_AUX) &&
                  sh_reg[3:2] == sel_reg[2:1];
  // Counter step that honours each area's wrap
  function automatic seer_addr_t step(input seer_addr_t a, input logic x, input logic [1:0] r);
    step = a;
    if (!x) begin
      step = a + 9'h001;
    end else if (r != `SEER_AREA_PROT) begin
      step = {a[8:4], a[3:0] + 4'h1};
    end
  endfunction
  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    bit_next = bit_reg;
    aux_next = aux_reg;
    area_next = area_reg;
    cnt_next = cnt_reg; // Held across operations, no per-frame clear
    sda_out_next = sda_out_reg;
    sda_oe_next = sda_oe_reg;
    if (start_det) begin
      // Restart drops any truncated write
      st_next = SEER_DEVSEL;
      bit_next = 4'h0;
      sda_oe_next = 1'b0;
    end else if (stop_det) begin
      st_next = SEER_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      case (st_reg)
        SEER_DEVSEL, SEER_WADDR, SEER_WDATA: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_s};
            bit_next = bit_reg + 4'h1;
          end
          if (scl_fall && bit_reg == 4'h8) begin
            bit_next = 4'h0;
            if (st_reg == SEER_DEVSEL) begin
              // Busy write cycle: NACK every select
              if (sel_ok && !busy_reg) begin
                aux_next = sh_reg[4];
                sda_out_next = 1'b0;
                sda_oe_next = 1'b1;
                st_next = SEER_DS_ACK;
                if (sh_reg[0] && !sh_reg[4]) begin
                  cnt_next = {sh_reg[1], cnt_reg[7:0]};
                end
              end else begin
                st_next = SEER_IGNORE;
              end
            end else if (st_reg == SEER_WADDR) begin
              area_next = sh_reg[7:6];
              cnt_next = aux_reg ? {5'h0, sh_reg[3:0]} : {cnt_reg[8], sh_reg};
              sda_out_next = 1'b0;
              sda_oe_next = 1'b1;
              st_next = SEER_WA_ACK;
            end else begin
              // Ident data ACK reports lock; data itself is written elsewhere
              sda_out_next = 1'b0;
              sda_oe_next = !(aux_reg && area_reg == `SEER_AREA_IDENT && lock_reg);
              st_next = SEER_WD_ACK;
            end
          end
        end
        SEER_DS_ACK, SEER_WA_ACK, SEER_WD_ACK: begin
          if (scl_fall) begin
            if (st_reg == SEER_DS_ACK && sh_reg[0]) begin
              // Send first byte right after the select ACK
              sh_next = rd_byte;
              sda_out_next = rd_byte[7];
              sda_oe_next = !rd_byte[7];
              bit_next = 4'h1;
              cnt_next = step(cnt_reg, aux_reg, area_reg);
              st_next = SEER_RDATA;
            end else begin
              sda_oe_next = 1'b0;
              st_next = (st_reg == SEER_DS_ACK) ? SEER_WADDR : SEER_WDATA;
            end
          end
        end
        SEER_RDATA: begin
          if (scl_fall) begin
            if (bit_reg == 4'h8) begin
              sda_oe_next = 1'b0; // Release for controller's ACK
              st_next = SEER_RD_ACK;
            end else begin
              sda_out_next = sh_reg[7 - bit_reg[2:0]];
              sda_oe_next = !sh_reg[7 - bit_reg[2:0]];
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        SEER_RD_ACK: begin
          if (scl_rise) begin
            // NACK ends the stream until the next start or stop
            st_next = sda_s ? SEER_IGNORE : SEER_RDATA;
            sh_next = rd_byte;
            bit_next = 4'h0;
          end
        end
        SEER_IGNORE, SEER_IDLE: sda_oe_next = 1'b0;
        default: st_next = SEER_IDLE;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= SEER_IDLE;
      sh_reg <= 8'h00;
      bit_reg <= 4'h0;
      aux_reg <= 1'b0;
      area_reg <= 2'h0;
      cnt_reg <= 9'h000;
      sda_out_reg <= 1'b1;
      sda_oe_reg <= 1'b0;
    end else if (clk_en) begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      bit_reg <= bit_next;
      aux_reg <= aux_next;
      area_reg <= area_next;
      cnt_reg <= (st_reg == SEER_RD_ACK && scl_rise && !sda_s) ?
                 step(cnt_reg, aux_reg, area_reg) : cnt_next;
      sda_out_reg <= sda_out_next;
      sda_oe_reg <= sda_oe_next;
    end
  end
  // Ident page content is zero until the write path fills it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        ident_mem[i] <= 8'h00;
      end
    end
  end
  assign sda_out = sda_out_reg;
  assign sda_oe = sda_oe_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_busy_nack: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == SEER_DEVSEL && busy_reg ##1 st_reg == SEER_DS_ACK |-> 1'b0)
    else $error("select acked while busy");
  a_prot_byte: assert property (@(posedge pclk) disable iff (!presetn)
    aux_reg && area_reg == `SEER_AREA_PROT |-> rd_byte[7:1] == 7'h00)
    else $error("protect byte upper bits set");
  a_ident_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    aux_reg && $changed(cnt_reg) && st_reg != SEER_WA_ACK && $past(st_reg) != SEER_WADDR
    |-> cnt_reg[8:4] == 5'h0)
    else $error("aux counter left its block");
  a_ack_drive: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == SEER_DS_ACK |-> sda_oe_reg && !sda_out_reg)
    else $error("select ack not driven");
  a_stop_idle: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && stop_det && !start_det |=> st_reg == SEER_IDLE && !sda_oe_reg)
    else $error("stop did not release");
  a_lock_nack: assert property (@(posedge pclk) disable iff (!presetn)
    st_reg == SEER_WD_ACK && aux_reg && area_reg == `SEER_AREA_IDENT && lock_reg
    |-> !sda_oe_reg)
    else $error("locked page data acked");
  // Every main-array byte launch steps the counter, so check the step into each data byte
  a_main_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    !aux_reg && st_reg == SEER_RDATA && $past(st_reg) != SEER_RDATA &&
    $past(cnt_reg) == 9'h1ff |-> cnt_reg == 9'h000)
    else $error("main counter did not wrap");
  a_prot_hold: assert property (@(posedge pclk) disable iff (!presetn)
    aux_reg && area_reg == `SEER_AREA_PROT && st_reg == SEER_RDATA |=> $stable(cnt_reg))
    else $error("protect read moved counter");
  c_read: cover property (@(posedge pclk) st_reg == SEER_RD_ACK ##[1:400] st_reg == SEER_RDATA);
  c_serial: cover property (@(posedge pclk) aux_reg && area_reg == `SEER_AREA_SERIAL &&
    st_reg == SEER_RDATA);
  c_apb: cover property (@(posedge pclk) acc && pwrite);
endmodule

// [verification/seer_ctl_model.sv]
// Purpose: Behavioural I2C bus controller facing the EEPROM read target.
// Assumes: The bench resolves the open-drain sda wire with a pull-up.
// Notes: scl period is 125 ns, moved in quarters kept off the pclk edges.
module seer_ctl_model (
  input wire logic pclk,
  input wire logic sda_line,
  output logic scl,
  output logic ctl_low
);
  timeunit 1ns;
  timeprecision 10ps;
  // ----------------------------------------
  // Bit level
  // ----------------------------------------
  logic [7:0] rbuf [0:15];
  // Idle bus: clock high, wire released
  initial begin
    scl = 1'b1;
    ctl_low = 1'b0;
  end
  // Quarter of the 125 ns link period
  task automatic hw(input int n);
    repeat (n) #31.25;
  endtask
  // Offset from a pclk edge so no quarter lands on one
  task automatic align();
    @(posedge pclk);
    #1;
  endtask
  // Data moves mid-low, sampled mid-high, so no edge race
  task automatic bit_cyc(input logic low, output logic seen);
    ctl_low <= low;
    hw(1);
    scl <= 1'b1;
    hw(1);
    seen = sda_line;
    hw(1);
    scl <= 1'b0;
    hw(1);
  endtask
  task automatic start();
    ctl_low <= 1'b0;
    hw(1);
    scl <= 1'b1;
    hw(1);
    ctl_low <= 1'b1; // Falling sda while scl high
    hw(1);
    scl <= 1'b0;
    hw(1);
  endtask
  task automatic stop();
    ctl_low <= 1'b1;
    hw(1);
    scl <= 1'b1;
    hw(1);
    ctl_low <= 1'b0;
    hw(2);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(!b[i], s);
    bit_cyc(1'b0, nak);
  endtask
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cyc(1'b0, s);
      b[i] = s;
    end
    bit_cyc(ack, s);
  endtask
  // ----------------------------------------
  // Transfers
  // ----------------------------------------
  // Dummy write then restart; ACK all bytes but the last
  task automatic xfer(input logic [3:0] typ, input logic [2:0] sel, input logic dum,
                      input logic [7:0] wa, input int n, output logic nak);
    logic a;
    nak = 1'b0;
    align();
    start();
    if (dum) begin
      wr_byte({typ, sel, 1'b0}, a);
      nak |= a;
      wr_byte(wa, a);
      nak |= a;
      start();
    end
    wr_byte({typ, sel, 1'b1}, a); // Read direction
    nak |= a;
    if (!a) for (int k = 0; k < n; k++) rd_byte(k != n - 1, rbuf[k]);
    stop();
  endtask
  // Truncated write, then start and stop to discard it
  task automatic trunc(input logic [7:0] wa, input logic [7:0] d, output logic nak);
    logic a;
    align();
    start();
    wr_byte(8'hb0, a);
    wr_byte(wa, a);
    wr_byte(d, nak);
    start();
    stop();
  endtask
endmodule

// [verification/seer_top_test.sv]
// Purpose: Self-checking bench for the EEPROM read target.
// Assumes: Controller model on the link, APB master tasks here.
// Notes: Main array and ident page hold zeros; counter seen via ADDR.
module seer_top_test;
  import seer_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  localparam logic [127:0] SER = 128'h1f2e3d4c_5b6a7988_97a6b5c4_d3e2f101; // Arbitrary value
  typedef struct {
    logic [3:0] typ; logic [2:0] sel; logic dum; logic [7:0] wa; int n;
    logic ser; logic [3:0] idx; logic nak; logic [8:0] cnt; logic [8:0] msk;
  } seer_row_s;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic wp_pin = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sda_out, sda_oe, scl, ctl_low, sda_line;
  int error_cnt = 0, checks = 0;
  // Pull-up wire: low when either party pulls
  assign sda_line = !(ctl_low || (sda_oe && !sda_out));
  always #5 pclk = ~pclk;
  seer_top #(.SERIAL_VALUE(SER)) uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .wp_pin(wp_pin));
  seer_ctl_model ctl (.pclk(pclk), .sda_line(sda_line), .scl(scl), .ctl_low(ctl_low));
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("ERROR t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Held until pready is sampled high; no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && t < 100) begin
      @(posedge pclk);
      t++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 100) chk(1, 0);
  endtask
  function automatic logic [7:0] ser_byte(input logic [3:0] k);
    return SER[127 - 8 * k -: 8];
  endfunction
  // ----------------------------------------
  // Cases
  // ----------------------------------------
  seer_row_s rows [0:10] = '{
    '{4'ha, 3'b001, 1, 8'hfe, 3, 0, 4'h0, 0, 9'h001, 9'h1ff},
    '{4'ha, 3'b000, 0, 8'h00, 2, 0, 4'h0, 0, 9'h003, 9'h1ff},
    '{4'hb, 3'b000, 1, 8'h0e, 3, 0, 4'h0, 0, 9'h001, 9'h00f},
    '{4'hb, 3'b000, 1, 8'h35, 1, 0, 4'h0, 0, 9'h006, 9'h00f},
    '{4'ha, 3'b000, 0, 8'h00, 1, 0, 4'h0, 0, 9'h007, 9'h00f},
    '{4'hb, 3'b000, 1, 8'h4e, 3, 1, 4'he, 0, 9'h001, 9'h00f},
    '{4'hb, 3'b000, 1, 8'h40, 16, 1, 4'h0, 0, 9'h000, 9'h00f},
    '{4'hb, 3'b000, 1, 8'h7f, 2, 1, 4'hf, 0, 9'h001, 9'h00f},
    '{4'hb, 3'b000, 1, 8'hc0, 2, 0, 4'h0, 0, 9'h000, 9'h000},
    '{4'h9, 3'b000, 0, 8'h00, 1, 0, 4'h0, 1, 9'h000, 9'h000},
    '{4'ha, 3'b110, 0, 8'h00, 1, 0, 4'h0, 1, 9'h000, 9'h000}
  };
  // Table loop, then hand-written awkward cases
  initial begin
    logic [31:0] d;
    logic e, nak;
    logic [3:0] j;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk({28'h0, pready, pslverr, sda_oe, sda_out}, 32'h1);
    apb(0, 12'h008, 0, d, e);
    chk(d, 0);
    apb(0, 12'hffc, 0, d, e);
    chk({d[30:0], e}, 1);
    foreach (rows[r]) begin
      ctl.xfer(rows[r].typ, rows[r].sel, rows[r].dum, rows[r].wa, rows[r].n, nak);
      chk(nak, rows[r].nak);
      for (int k = 0; k < rows[r].n && !rows[r].nak; k++) begin
        j = rows[r].idx + k[3:0];
        chk(ctl.rbuf[k], rows[r].ser ? ser_byte(j) : 8'h00);
      end
      apb(0, 12'h008, 0, d, e);
      chk(d[8:0] & rows[r].msk, rows[r].cnt & rows[r].msk);
    end
    // Protect bit set and pin high: reads still served
    wp_pin <= 1'b1;
    apb(1, 12'h000, 32'h2, d, e);
    ctl.xfer(4'hb, 3'b000, 1, 8'hc0, 3, nak);
    chk(nak, 0);
    for (int k = 0; k < 3; k++) chk(ctl.rbuf[k], 8'h01);
    ctl.xfer(4'ha, 3'b000, 1, 8'h10, 1, nak);
    chk(nak, 0);
    // Internal write in progress refuses the select
    apb(1, 12'h000, 32'h1, d, e);
    ctl.xfer(4'ha, 3'b000, 0, 8'h00, 1, nak);
    chk(nak, 1);
    // Select pins programmed to 11 now match
    apb(1, 12'h000, 32'h60, d, e);
    ctl.xfer(4'ha, 3'b110, 0, 8'h00, 1, nak);
    chk(nak, 0);
    apb(1, 12'h000, 32'h0, d, e);
    // Serial block ignores a write attempt
    ctl.trunc(8'h40, 8'hff, nak);
    ctl.xfer(4'hb, 3'b000, 1, 8'h40, 1, nak);
    chk(ctl.rbuf[0], ser_byte(4'h0));
    // Lock probe before and after locking
    ctl.trunc(8'h00, 8'h5a, nak);
    chk(nak, 0);
    apb(1, 12'h000, 32'h4, d, e);
    ctl.trunc(8'h00, 8'h5a, nak);
    chk(nak, 1);
    ctl.xfer(4'hb, 3'b000, 1, 8'h03, 1, nak);
    chk(nak, 0);
    give_verdict();
  end
  // Whole run is near 100 us; the limit leaves ample margin
  initial begin
    #600000;
    error_cnt++;
    give_verdict();
  end
endmodule
